//--- logic/lad_distributor.sv
// link aggregation distributor with axi4-lite control
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "lad_params.svh"
`default_nettype none

module lad_distributor
  import lad_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // physical port state
  input wire logic [7:0] port_oper_up,
  input wire logic [7:0] port_is_logical,
  input wire logic [7:0] port_has_services,
  // frame header descriptor
  input wire logic fd_valid,
  output logic fd_ready,
  input wire logic [1:0] fd_group,
  input wire logic [47:0] fd_mac_da,
  input wire logic [47:0] fd_mac_sa,
  input wire logic [3:0] fd_mpls_cnt,
  input wire logic [95:0] fd_labels,
  input wire logic fd_is_ipv4,
  input wire logic [31:0] fd_ipv4_da,
  input wire logic [31:0] fd_ipv4_sa,
  input wire logic fd_is_ipv6,
  input wire logic [127:0] fd_ipv6_da,
  input wire logic [127:0] fd_ipv6_sa,
  input wire logic [19:0] fd_flow_label,
  input wire logic fd_is_l4,
  input wire logic [15:0] fd_l4_dport,
  input wire logic [15:0] fd_l4_sport,
  // distribution result
  output logic dist_valid,
  input wire logic dist_ready,
  output logic [2:0] dist_port,
  output logic dist_drop,
  // bandwidth notification
  input wire logic bnm_req,
  input wire logic [2:0] bnm_port,
  input wire logic [31:0] radio_bw,
  output logic [7:0] bnm_tx_mask,
  output logic [31:0] bnm_bw,
  // signal fail
  input wire logic csf_req,
  input wire logic [2:0] csf_port,
  output logic [7:0] csf_tx_mask,
  // group state and class
  output logic [3:0] grp_closed,
  output logic [3:0] grp_state_evt,
  output logic [23:0] port_eff_cos
);

  // ==========================================
  // helper functions
  function automatic logic [3:0] popcnt(input lad_pmask_t m);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < `LAD_NPORT; i++) begin
      c = c + {3'h0, m[i]};
    end
    return c;
  endfunction

  function automatic logic [2:0] nth_set(input lad_pmask_t m, input logic [3:0] n);
    logic [3:0] k;
    logic [2:0] r;
    k = 4'h0;
    r = 3'h0;
    for (int i = 0; i < `LAD_NPORT; i++) begin
      if (m[i]) begin
        if (k == n) begin
          r = 3'(i);
        end
        k = k + 4'h1;
      end
    end
    return r;
  endfunction

  // group that holds a port, bit 2 flags a hit
  function automatic logic [2:0] grp_of(input lad_pmask_t mb [4], input logic [2:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int g = 0; g < `LAD_NGRP; g++) begin
      if (mb[g][p]) begin
        r = {1'b1, 2'(g)};
      end
    end
    return r;
  endfunction

  // ==========================================
  // state
  // four group slots only
  logic [7:0] grp_cfg_reg [4];
  lad_pmask_t member_reg [4];
  logic [4:0] port_cfg_reg [8];
  logic [3:0] closed_reg;
  logic [3:0] evt_reg;
  logic refused_reg;
  lad_wr_state_t wr_state_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_strb_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // ==========================================
  // axi write channel
  logic wr_fire;
  logic wr_en;
  assign s_axi_awready = !aw_got_reg && wr_state_reg == LAD_WR_IDLE;
  assign s_axi_wready = !w_got_reg && wr_state_reg == LAD_WR_IDLE;
  assign s_axi_bvalid = wr_state_reg == LAD_WR_RESP;
  assign s_axi_bresp = bresp_reg;
  assign wr_fire = aw_got_reg && w_got_reg && wr_state_reg == LAD_WR_IDLE;
  assign wr_en = wr_fire && w_strb_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_byte_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      wr_state_reg <= LAD_WR_IDLE;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      case (wr_state_reg)
        LAD_WR_IDLE: begin
          if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            wr_state_reg <= LAD_WR_RESP;
          end
        end
        LAD_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= LAD_WR_IDLE;
          end
        end
        default: wr_state_reg <= LAD_WR_IDLE;
      endcase
    end
  end

  // write address check
  logic wr_mapped;
  always_comb begin
    if (aw_addr_reg[1:0] != 2'h0) begin
      wr_mapped = 1'b0;
    end else if (aw_addr_reg < `LAD_GRP_MBR_BASE) begin
      wr_mapped = 1'b1;
    end else if (aw_addr_reg == `LAD_MBR_CMD || aw_addr_reg == `LAD_STATUS) begin
      wr_mapped = 1'b1;
    end else if (aw_addr_reg >= `LAD_PORT_CFG_BASE && aw_addr_reg < `LAD_STATUS) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_reg <= `LAD_RESP_OKAY;
    end else if (wr_fire) begin
      bresp_reg <= wr_mapped ? `LAD_RESP_OKAY : `LAD_RESP_SLVERR;
    end
  end

  // ==========================================
  // membership command
  logic cmd_wr;
  logic [2:0] cmd_port;
  logic [1:0] cmd_grp;
  logic cmd_add;
  logic cmd_ok;
  logic [2:0] cmd_owner;
  assign cmd_wr = wr_en && aw_addr_reg == `LAD_MBR_CMD;
  assign cmd_port = w_byte_reg[`LAD_C_PORT_LSB +: 3];
  assign cmd_grp = w_byte_reg[`LAD_C_GRP_LSB +: 2];
  assign cmd_add = w_byte_reg[`LAD_C_ADD];
  assign cmd_owner = grp_of(member_reg, cmd_port);
  assign cmd_ok = cmd_add ? (!port_is_logical[cmd_port] && !port_has_services[cmd_port]
                             && !cmd_owner[2])
                          : member_reg[cmd_grp][cmd_port];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int g = 0; g < `LAD_NGRP; g++) begin
        member_reg[g] <= 8'h00;
      end
    end else if (cmd_wr && cmd_ok) begin
      member_reg[cmd_grp][cmd_port] <= cmd_add;
    end
  end

  // ==========================================
  // group configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int g = 0; g < `LAD_NGRP; g++) begin
        grp_cfg_reg[g] <= `LAD_GRP_CFG_RST;
      end
    end else if (wr_en && aw_addr_reg < `LAD_GRP_MBR_BASE) begin
      grp_cfg_reg[aw_addr_reg[3:2]] <= w_byte_reg;
      grp_cfg_reg[aw_addr_reg[3:2]][`LAD_G_MACT] <=
        w_byte_reg[`LAD_G_MACT] && w_byte_reg[`LAD_G_MHOME];
    end
  end

  // ==========================================
  // port configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < `LAD_NPORT; p++) begin
        port_cfg_reg[p] <= `LAD_PORT_CFG_RST;
      end
    end else if (cmd_wr && cmd_ok && !cmd_add) begin
      port_cfg_reg[cmd_port] <= `LAD_PORT_CFG_RST;
    end else if (wr_en && aw_addr_reg >= `LAD_PORT_CFG_BASE && aw_addr_reg < `LAD_STATUS) begin
      port_cfg_reg[aw_addr_reg[4:2]] <= w_byte_reg[4:0];
    end
  end

  // ==========================================
  // degradation shutdown per group
  logic [3:0] closed_next;
  logic sts_wr;
  assign sts_wr = wr_en && aw_addr_reg == `LAD_STATUS;

  generate
    for (genvar g = 0; g < `LAD_NGRP; g++) begin : g_grp
      logic any_down;
      assign any_down = |(member_reg[g] & ~port_oper_up);
      always_comb begin
        if (!grp_cfg_reg[g][`LAD_G_DEGR]) begin
          closed_next[g] = 1'b0;
        end else if (any_down) begin
          closed_next[g] = 1'b1;
        end else begin
          closed_next[g] = 1'b0;
        end
      end
      // close and reopen events, set beats clear
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          evt_reg[g] <= 1'b0;
        end else if (closed_next[g] != closed_reg[g]) begin
          evt_reg[g] <= 1'b1;
        end else if (sts_wr && w_byte_reg[`LAD_S_EVT_LSB + g]) begin
          evt_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      closed_reg <= 4'h0;
      grp_state_evt <= 4'h0;
    end else begin
      closed_reg <= closed_next;
      grp_state_evt <= closed_next ^ closed_reg;
    end
  end
  assign grp_closed = closed_reg;

  // refused command flag; set by a refused command, a status write never clears it, only reset does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_reg <= 1'b0;
    end else if (cmd_wr && !cmd_ok) begin
      refused_reg <= 1'b1;
    end else if (sts_wr && s_axi_wstrb[1] == 1'b0) begin
      refused_reg <= refused_reg;
    end
  end

  // ==========================================
  // effective class per port
  // group class overrides member class
  generate
    for (genvar p = 0; p < `LAD_NPORT; p++) begin : g_cos
      logic [2:0] own;
      assign own = grp_of(member_reg, 3'(p));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          port_eff_cos[3*p +: 3] <= 3'h0;
        end else if (own[2]) begin
          port_eff_cos[3*p +: 3] <= grp_cfg_reg[own[1:0]][`LAD_G_COS_LSB +: 3];
        end else begin
          port_eff_cos[3*p +: 3] <= port_cfg_reg[p][`LAD_P_COS_LSB +: 3];
        end
      end
    end
  endgenerate

  // ==========================================
  // distribution hash
  logic [31:0] hash_acc;
  logic [15:0] hash16;
  always_comb begin
    hash_acc = 32'h0;
    if (fd_mpls_cnt == 4'h0) begin
      hash_acc = hash_acc ^ fd_mac_da[31:0] ^ fd_mac_sa[31:0]
                 ^ {fd_mac_da[47:32], fd_mac_sa[47:32]};
    end
    for (int i = 0; i < `LAD_MAX_LBL; i++) begin
      if (fd_mpls_cnt > 4'(i)) begin
        hash_acc = hash_acc ^ (fd_labels[32*i +: 32] & `LAD_LBL_MASK);
      end
    end
    if (fd_mpls_cnt <= 4'(`LAD_MAX_LBL)) begin
      if (fd_is_ipv4) begin
        hash_acc = hash_acc ^ fd_ipv4_da ^ fd_ipv4_sa;
      end
      if (fd_is_ipv6) begin
        for (int j = 0; j < 4; j++) begin
          hash_acc = hash_acc ^ (fd_ipv6_da[32*j +: 32] & 32'(`LAD_V6DA_MASK >> (32*j)))
                     ^ fd_ipv6_sa[32*j +: 32];
        end
      end
      if (fd_is_l4) begin
        hash_acc = hash_acc ^ {fd_l4_dport, fd_l4_sport};
      end
    end
    if (fd_is_ipv6) begin
      hash_acc = hash_acc ^ {12'h000, fd_flow_label};
    end
    hash16 = hash_acc[31:16] ^ hash_acc[15:0];
  end

  // ==========================================
  // member selection
  lad_pmask_t elig;
  logic [3:0] elig_cnt;
  logic [3:0] pick;
  logic blocked;
  assign elig = member_reg[fd_group] & port_oper_up;
  assign elig_cnt = popcnt(elig);
  assign pick = (elig_cnt == 4'h0) ? 4'h0 : 4'(hash16 % {12'h000, elig_cnt});
  assign blocked = !grp_cfg_reg[fd_group][`LAD_G_ADMIN] || closed_reg[fd_group]
                   || elig_cnt == 4'h0;
  assign fd_ready = !dist_valid || dist_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dist_valid <= 1'b0;
      dist_port <= 3'h0;
      dist_drop <= 1'b0;
    end else if (fd_ready) begin
      dist_valid <= fd_valid;
      if (fd_valid) begin
        dist_port <= nth_set(elig, pick);
        dist_drop <= blocked;
      end
    end
  end

  // ==========================================
  // bnm and csf replication
  logic [2:0] bnm_own;
  logic [2:0] csf_own;
  lad_pmask_t bnm_grp_mbr;
  lad_pmask_t csf_grp_mbr;
  lad_pmask_t bn_en;
  lad_pmask_t safe_en;
  logic bnm_mh;
  logic csf_mh;
  logic [3:0] act_cnt;
  always_comb begin
    for (int p = 0; p < `LAD_NPORT; p++) begin
      bn_en[p] = port_cfg_reg[p][`LAD_P_BN];
      safe_en[p] = port_cfg_reg[p][`LAD_P_SAFE];
    end
  end
  assign bnm_own = grp_of(member_reg, bnm_port);
  assign csf_own = grp_of(member_reg, csf_port);
  assign bnm_grp_mbr = member_reg[bnm_own[1:0]];
  assign csf_grp_mbr = member_reg[csf_own[1:0]];
  assign bnm_mh = bnm_own[2] && grp_cfg_reg[bnm_own[1:0]][`LAD_G_MHOME];
  assign csf_mh = csf_own[2] && grp_cfg_reg[csf_own[1:0]][`LAD_G_MHOME];
  assign act_cnt = popcnt(bnm_grp_mbr & port_oper_up);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bnm_tx_mask <= 8'h00;
      bnm_bw <= 32'h0;
    end else if (!bnm_req) begin
      bnm_tx_mask <= 8'h00;
    end else if (bnm_mh && |(bnm_grp_mbr & bn_en)) begin
      bnm_tx_mask <= bnm_grp_mbr;
      if (grp_cfg_reg[bnm_own[1:0]][`LAD_G_MACT] && act_cnt != 4'h0) begin
        bnm_bw <= radio_bw / {28'h0, act_cnt};
      end else begin
        bnm_bw <= radio_bw;
      end
    end else begin
      bnm_tx_mask <= bn_en[bnm_port] ? (8'h01 << bnm_port) : 8'h00;
      bnm_bw <= radio_bw;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csf_tx_mask <= 8'h00;
    end else if (!csf_req) begin
      csf_tx_mask <= 8'h00;
    end else if (csf_mh && |(csf_grp_mbr & safe_en)) begin
      csf_tx_mask <= csf_grp_mbr;
    end else begin
      csf_tx_mask <= safe_en[csf_port] ? (8'h01 << csf_port) : 8'h00;
    end
  end

  // ==========================================
  // axi read channel
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    if (s_axi_araddr[1:0] != 2'h0) begin
      rd_ok = 1'b0;
    end else if (s_axi_araddr < `LAD_GRP_MBR_BASE) begin
      rd_word = {24'h0, grp_cfg_reg[s_axi_araddr[3:2]]};
    end else if (s_axi_araddr < `LAD_MBR_CMD) begin
      rd_word = {24'h0, member_reg[s_axi_araddr[3:2]]};
    end else if (s_axi_araddr == `LAD_MBR_CMD) begin
      rd_word = 32'h0;
    end else if (s_axi_araddr >= `LAD_PORT_CFG_BASE && s_axi_araddr < `LAD_STATUS) begin
      rd_word = {27'h0, port_cfg_reg[s_axi_araddr[4:2]]};
    end else if (s_axi_araddr == `LAD_STATUS) begin
      rd_word = {23'h0, refused_reg, evt_reg, closed_reg};
    end else if (s_axi_araddr == `LAD_PORT_STATE) begin
      rd_word = {24'h0, port_oper_up};
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `LAD_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_ok ? `LAD_RESP_OKAY : `LAD_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- logic/lad_params.svh
// constants for the link aggregation distributor
`ifndef LAD_PARAMS_SVH
`define LAD_PARAMS_SVH

// ==========================================
// sizes
`define LAD_NPORT 8
`define LAD_NGRP 4
`define LAD_MAX_LBL 3

// ==========================================
// register byte offsets
`define LAD_GRP_CFG_BASE 8'h00
`define LAD_GRP_MBR_BASE 8'h10
`define LAD_MBR_CMD 8'h20
`define LAD_PORT_CFG_BASE 8'h40
`define LAD_STATUS 8'h60
`define LAD_PORT_STATE 8'h64

// ==========================================
// group config fields
`define LAD_G_ADMIN 0
`define LAD_G_DEGR 1
`define LAD_G_LACP 2
`define LAD_G_MHOME 3
`define LAD_G_MACT 4
`define LAD_G_COS_LSB 5
`define LAD_GRP_CFG_RST 8'h00

// port config fields
`define LAD_P_BN 0
`define LAD_P_SAFE 1
`define LAD_P_COS_LSB 2
`define LAD_PORT_CFG_RST 5'h00

// member command fields
`define LAD_C_PORT_LSB 0
`define LAD_C_GRP_LSB 4
`define LAD_C_ADD 7

// status fields
`define LAD_S_EVT_LSB 4
`define LAD_S_REFUSED 8

// ==========================================
// hash masks
`define LAD_LBL_MASK 32'hffe1ff1f
`define LAD_V6DA_MASK 128'hffffffffff00ffffffffffffffffffff

// bus answers
`define LAD_RESP_OKAY 2'h0
`define LAD_RESP_SLVERR 2'h2

`endif

//--- logic/lad_pkg.sv
// types for the link aggregation distributor
package lad_pkg;

  typedef enum logic [0:0] {
    LAD_WR_IDLE = 1'b0,
    LAD_WR_RESP = 1'b1
  } lad_wr_state_t;

  typedef logic [7:0] lad_pmask_t;

endpackage

//--- verification/lad_props.sv
// assertions on the distributor ports
`timescale 1ns/10ps
`default_nettype none
module lad_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // frames
  input wire logic fd_valid,
  input wire logic fd_ready,
  input wire logic [1:0] fd_group,
  input wire logic dist_valid,
  input wire logic dist_ready,
  input wire logic [2:0] dist_port,
  input wire logic dist_drop,
  // notifications and group state
  input wire logic bnm_req,
  input wire logic [7:0] bnm_tx_mask,
  input wire logic [31:0] bnm_bw,
  input wire logic csf_req,
  input wire logic [7:0] csf_tx_mask,
  input wire logic [3:0] grp_closed,
  input wire logic [3:0] grp_state_evt
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================
  // register bus
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  property p_wr_answer;
    s_wr_take |=> s_wr_answer;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer off time");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");

  // ==========================================
  // frames
  property p_fd_ready;
    fd_ready == (!dist_valid || dist_ready);
  endproperty
  a_fd_ready: assert property (p_fd_ready) else $error("descriptor ready wrong");
  property p_dist_hold;
    dist_valid && !dist_ready |=> dist_valid && $stable({dist_port, dist_drop});
  endproperty
  a_dist_hold: assert property (p_dist_hold) else $error("result changed early");
  property p_closed_drop;
    fd_valid && fd_ready && grp_closed[fd_group] |=> dist_valid && dist_drop;
  endproperty
  a_closed_drop: assert property (p_closed_drop) else $error("closed group passed");

  // ==========================================
  // group state and notifications
  property p_state_evt;
    grp_state_evt == (grp_closed ^ $past(grp_closed));
  endproperty
  a_state_evt: assert property (p_state_evt) else $error("state event mismatch");
  property p_bnm_mask;
    bnm_tx_mask != 8'h00 |-> $past(bnm_req);
  endproperty
  a_bnm_mask: assert property (p_bnm_mask) else $error("bnm without request");
  property p_csf_mask;
    csf_tx_mask != 8'h00 |-> $past(csf_req);
  endproperty
  a_csf_mask: assert property (p_csf_mask) else $error("csf without request");
  property p_bw_hold;
    !$past(bnm_req) |-> $stable(bnm_bw);
  endproperty
  a_bw_hold: assert property (p_bw_hold) else $error("bandwidth moved");
endmodule
`default_nettype wire

//--- verification/lad_fabric_model.sv
// fabric side model that takes distribution results
`timescale 1ns/10ps
`default_nettype none
module lad_fabric_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pacing and handshake
  input wire logic stall,
  output logic dist_ready
);
  logic [7:0] lf_reg;
  // slow mode withholds ready on a pseudo-random half of the cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_reg <= 8'ha5;
      dist_ready <= 1'b0;
    end else begin
      lf_reg <= {lf_reg[6:0], lf_reg[7] ^ lf_reg[5] ^ lf_reg[4] ^ lf_reg[3]};
      dist_ready <= !stall || lf_reg[0];
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// bench for the link aggregation distributor
`timescale 1ns/10ps
`include "lad_params.svh"
`default_nettype none
module tb_top import lad_pkg::*; ;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic fd_valid, fd_ready, fd_is_ipv4, fd_is_ipv6, fd_is_l4, dist_valid, dist_ready;
  logic dist_drop, bnm_req, csf_req, stall;
  logic [1:0] s_axi_bresp, s_axi_rresp, fd_group, r;
  logic [2:0] dist_port, bnm_port, csf_port;
  logic [3:0] s_axi_wstrb, fd_mpls_cnt, grp_closed, grp_state_evt, a, b;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port_oper_up, port_is_logical, port_has_services;
  logic [7:0] bnm_tx_mask, csf_tx_mask;
  logic [15:0] fd_l4_dport, fd_l4_sport;
  logic [19:0] fd_flow_label;
  logic [23:0] port_eff_cos;
  logic [31:0] s_axi_wdata, s_axi_rdata, radio_bw, bnm_bw, fd_ipv4_da, fd_ipv4_sa, rs, d;
  logic [47:0] fd_mac_da, fd_mac_sa;
  logic [95:0] fd_labels;
  logic [127:0] fd_ipv6_da, fd_ipv6_sa;
  int miscompares, checked, i, k;

  lad_distributor lad_distributor_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_oper_up, .port_is_logical,
    .port_has_services, .fd_valid, .fd_ready, .fd_group, .fd_mac_da, .fd_mac_sa, .fd_mpls_cnt,
    .fd_labels, .fd_is_ipv4, .fd_ipv4_da, .fd_ipv4_sa, .fd_is_ipv6, .fd_ipv6_da, .fd_ipv6_sa,
    .fd_flow_label, .fd_is_l4, .fd_l4_dport, .fd_l4_sport, .dist_valid, .dist_ready,
    .dist_port, .dist_drop, .bnm_req, .bnm_port, .radio_bw, .bnm_tx_mask, .bnm_bw, .csf_req,
    .csf_port, .csf_tx_mask, .grp_closed, .grp_state_evt, .port_eff_cos);
  lad_fabric_model lad_fabric_model_i (.aclk, .aresetn, .stall, .dist_ready);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] share(input logic [31:0] bw, input lad_pmask_t m);
    return bw / 32'($countones(m));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("counts: %0d compared, %0d wrong", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    summarize();
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) hang();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    int n;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) hang();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic frame(output logic [3:0] res);
    int n;
    @(posedge aclk);
    fd_valid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (fd_ready) break;
    end
    fd_valid <= 1'b0;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (dist_valid && dist_ready) break;
    end
    if (n == 40 || k == 40) hang();
    res = {dist_drop, dist_port};
  endtask
  task automatic fill(input logic [3:0] cnt);
    rs = lfsr(rs);
    fd_mpls_cnt <= cnt;
    fd_mac_da <= {rs, ~rs[15:0]};
    fd_mac_sa <= {rs[15:0], rs ^ 32'h5a5a};
    fd_labels <= {rs, ~rs, lfsr(rs)};
    fd_ipv4_da <= ~rs;
    fd_ipv4_sa <= lfsr(~rs);
    fd_ipv6_da <= {4{rs}};
    fd_ipv6_sa <= {4{~rs}};
    fd_flow_label <= rs[19:0];
    fd_l4_dport <= rs[31:16];
    fd_l4_sport <= rs[15:0];
    fd_is_ipv6 <= rs[5] || cnt == 4'h0;
    fd_is_ipv4 <= !rs[5];
    fd_is_l4 <= rs[6];
  endtask
  // base frame, then a twin differing only where the hash must not look
  task automatic pair(input int v);
    case (v)
      1: fill(4'h1);
      3: fill(4'h2);
      2, 4, 5: fill(4'h4);
      default: fill(4'h0);
    endcase
    frame(a);
    case (v)
      1: fd_mac_da <= ~fd_mac_da;
      2: fd_mpls_cnt <= 4'h7;
      3: fd_labels <= fd_labels ^ {3{~`LAD_LBL_MASK}};
      4: fd_ipv4_sa <= ~fd_ipv4_sa;
      5: fd_l4_dport <= ~fd_l4_dport;
      6: fd_ipv6_da <= fd_ipv6_da ^ ~`LAD_V6DA_MASK;
      default: ;
    endcase
    frame(b);
    check(32'(b), 32'(a));
    check(32'(a[3] || a[2:0] > 3'h2), 32'h0);
  endtask

  // ==========================================
  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr,
     s_axi_arvalid, s_axi_rready, port_is_logical, port_has_services, fd_valid, fd_group,
     bnm_req, bnm_port, radio_bw, csf_req, csf_port, stall} = '0;
    s_axi_wstrb = 4'hf;
    port_oper_up = 8'hff;
    rs = 32'hfca5;
    aresetn = 1'b0;
    fill(4'h0);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LAD_GRP_CFG_BASE);
    check(d, 32'h0);
    rd(8'h70);
    check(32'(r), 32'(`LAD_RESP_SLVERR));
    wr(`LAD_GRP_CFG_BASE + 8'h10, 32'h01);
    check(32'(r), 32'(`LAD_RESP_SLVERR));
    wr(`LAD_PORT_CFG_BASE + 8'h04, 32'h0c);
    wr(`LAD_GRP_CFG_BASE, 32'ha1);
    check(32'(r), 32'(`LAD_RESP_OKAY));
    for (i = 0; i < 3; i++) wr(`LAD_MBR_CMD, 32'h80 | 32'(i));
    rd(`LAD_GRP_MBR_BASE);
    check(d, 32'h07);
    check(32'(port_eff_cos[5:3]), 32'h5);
    port_is_logical <= 8'h20;
    port_has_services <= 8'h40;
    wr(`LAD_MBR_CMD, 32'h85);
    rd(`LAD_STATUS);
    check(32'(d[8]), 32'h1);
    wr(`LAD_MBR_CMD, 32'h86);
    rd(`LAD_GRP_MBR_BASE);
    check(d, 32'h07);
    $display("test membership done");
    for (i = 0; i < 6; i++) begin
      stall <= i[0];
      for (int v = 0; v < 7; v++) pair(v);
    end
    port_oper_up <= 8'hfd;
    for (i = 0; i < 8; i++) begin
      fill(4'h0);
      frame(a);
      check(32'(a[3] || a[2:0] == 3'h1), 32'h0);
    end
    $display("test distribution done");
    wr(`LAD_GRP_CFG_BASE, 32'ha0);
    frame(a);
    check(32'(a[3]), 32'h1);
    wr(`LAD_GRP_CFG_BASE, 32'ha3);
    port_oper_up <= 8'hfb;
    repeat (3) @(posedge aclk);
    check(32'(grp_closed), 32'h1);
    frame(a);
    check(32'(a[3]), 32'h1);
    rd(`LAD_STATUS);
    check(d, 32'h111);
    port_oper_up <= 8'hff;
    repeat (3) @(posedge aclk);
    check(32'(grp_closed), 32'h0);
    $display("test degradation done");
    wr(`LAD_GRP_CFG_BASE, 32'hb9);
    wr(`LAD_PORT_CFG_BASE + 8'h04, 32'h03);
    port_oper_up <= 8'hfb;
    rs = lfsr(rs);
    @(posedge aclk);
    bnm_req <= 1'b1;
    csf_req <= 1'b1;
    bnm_port <= 3'h1;
    csf_port <= 3'h1;
    radio_bw <= rs;
    @(posedge aclk);
    bnm_req <= 1'b0;
    csf_req <= 1'b0;
    @(posedge aclk);
    check(32'(bnm_tx_mask), 32'h07);
    check(32'(csf_tx_mask), 32'h07);
    check(bnm_bw, share(rs, 8'h03));
    wr(`LAD_GRP_CFG_BASE + 8'h04, 32'h10);
    rd(`LAD_GRP_CFG_BASE + 8'h04);
    check(d, 32'h0);
    wr(`LAD_MBR_CMD, 32'h01);
    rd(`LAD_PORT_CFG_BASE + 8'h04);
    check(d, 32'h0);
    $display("test multi-homing done");
    summarize();
  end
endmodule

bind lad_distributor lad_props lad_props_i (.*);
`default_nettype wire
